//--- rtl/mapper_params.svh
`ifndef MAPPER_PARAMS_SVH
`define MAPPER_PARAMS_SVH
// ==========================================
// register offsets
`define ZERO_PAGE_OFS    8'h11
`define VIS_CTRL_OFS     8'h13
`define PROG_PAGE_OFS    8'h15
`define RAM_PAGE_OFS     8'h16
`define DATA_PAGE_OFS    8'h17
// ==========================================
// reset values
`define ZERO_PAGE_RST    8'h00
`define PROG_PAGE_RST    8'hFE
`define RAM_PAGE_RST     8'hFD
`define DATA_PAGE_RST    8'hFE
// ==========================================
// visibility control fields
`define VIS_SCRATCH_BIT  7
`define VIS_DATA_ROW_BIT 5
`define VIS_PROG_ROW_BIT 4
`define VIS_WR_MASK      8'hB0
// ==========================================
// local windows, base and mask
`define DATA_WIN_BASE    16'h0800
`define DATA_FIX_BASE    16'h0C00
`define DATA_WIN_MASK    16'hFC00
`define RAM_WIN_BASE     16'h1000
`define RAM_FIX_LO_BASE  16'h2000
`define RAM_FIX_HI_BASE  16'h3000
`define RAM_WIN_MASK     16'hF000
`define PROG_LIN_BASE    16'h4000
`define PROG_WIN_BASE    16'h8000
`define PROG_FIX_BASE    16'hC000
`define PROG_WIN_MASK    16'hC000
// ==========================================
// fixed pages and global prefixes
`define PROG_FIX_PAGE    8'hFF
`define PROG_LIN_PAGE    8'hFD
`define RAM_FIX_LO_PAGE  8'hFE
`define RAM_FIX_HI_PAGE  8'hFF
`define DATA_FIX_PAGE    8'hFF
`define REG_SPACE_PAGE   8'h00
`define PROG_OFS_W       14
`define RAM_OFS_W        12
`define DATA_OFS_W       10
`define PROG_PREFIX      1'h1
`define RAM_PREFIX       3'h0
`define DATA_PREFIX      5'h04
`define REG_PREFIX       7'h00
`define RAM_TOP          32'h0010_0000
`define RAM_SIZE_DEFAULT 32'h0000_3000
`define PROG_ROW_BASE    23'h40_0000
`define PROG_ROW_MASK    23'h7F_C000
`endif

//--- rtl/mapper_pkg.sv
package mapper_pkg;
  // ==========================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic        debug;
    logic        direct;
    logic        global_inst;
    logic [15:0] addr;
  } local_access_t;

  typedef struct packed {
    logic        valid;
    logic        debug;
    logic [22:0] addr;
    logic        register_space;
    logic        unimplemented;
    logic        prog_row_hit;
  } global_access_t;

  typedef struct packed {
    logic scratch_ram_visible;
    logic data_info_row_visible;
    logic program_info_row_visible;
  } visibility_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  // write-once state of the zero page index
  typedef enum logic {
    ZP_OPEN   = 1'b0,
    ZP_LOCKED = 1'b1
  } zero_page_lock_t;
endpackage

//--- rtl/address_expander.sv
`timescale 1ns/1ps
`include "mapper_params.svh"
module address_expander
  import mapper_pkg::*;
(
  // local request and page indices
  input  local_access_t req,
  input  wire logic [7:0]  zero_page_bits,
  input  wire logic [7:0]  program_page_index,
  input  wire logic [7:0]  ram_page_index,
  input  wire logic [7:0]  data_flash_page_index,
  input  wire logic [6:0]  global_page_index,
  // expanded address
  output logic [22:0] global_addr,
  output logic        ram_access
);
  // ==========================================
  // window decode
  function automatic logic in_win(input logic [15:0] a, input logic [15:0] base, input logic [15:0] mask);
    return (a & mask) == base;
  endfunction

  // direct mode puts the zero page on the high byte
  logic [15:0] local_addr;
  assign local_addr = req.direct ? {zero_page_bits, req.addr[7:0]} : req.addr;

  logic data_paged, data_fixed, ram_paged, ram_lo, ram_hi;
  logic prog_lin, prog_paged, prog_fixed;
  assign data_paged = in_win(local_addr, `DATA_WIN_BASE, `DATA_WIN_MASK);
  assign data_fixed = in_win(local_addr, `DATA_FIX_BASE, `DATA_WIN_MASK);
  assign ram_paged  = in_win(local_addr, `RAM_WIN_BASE, `RAM_WIN_MASK);
  assign ram_lo     = in_win(local_addr, `RAM_FIX_LO_BASE, `RAM_WIN_MASK);
  assign ram_hi     = in_win(local_addr, `RAM_FIX_HI_BASE, `RAM_WIN_MASK);
  assign prog_lin   = in_win(local_addr, `PROG_LIN_BASE, `PROG_WIN_MASK);
  assign prog_paged = in_win(local_addr, `PROG_WIN_BASE, `PROG_WIN_MASK);
  assign prog_fixed = in_win(local_addr, `PROG_FIX_BASE, `PROG_WIN_MASK);

  // ==========================================
  // page selection, same for cpu and debug unit
  logic [7:0] prog_sel, ram_sel, data_sel;
  assign prog_sel = prog_paged ? program_page_index :
                    prog_fixed ? `PROG_FIX_PAGE : `PROG_LIN_PAGE;
  assign ram_sel  = ram_paged ? ram_page_index :
                    ram_lo ? `RAM_FIX_LO_PAGE : `RAM_FIX_HI_PAGE;
  assign data_sel = data_paged ? data_flash_page_index : `DATA_FIX_PAGE;

  logic [22:0] expanded;
  assign expanded = (prog_lin | prog_paged | prog_fixed) ?
                      {`PROG_PREFIX, prog_sel, local_addr[`PROG_OFS_W-1:0]} :
                    (ram_paged | ram_lo | ram_hi) ?
                      {`RAM_PREFIX, ram_sel, local_addr[`RAM_OFS_W-1:0]} :
                    (data_paged | data_fixed) ?
                      {`DATA_PREFIX, data_sel, local_addr[`DATA_OFS_W-1:0]} :
                      {`REG_PREFIX, local_addr};

  // global instructions bypass the windows entirely
  assign global_addr = req.global_inst ? {global_page_index, local_addr} : expanded;
  assign ram_access  = !req.global_inst && (ram_paged | ram_lo | ram_hi);
endmodule

//--- rtl/page_window_address_mapper.sv
`timescale 1ns/1ps
`include "mapper_params.svh"
module page_window_address_mapper
  import mapper_pkg::*;
#(
  parameter int unsigned RAM_SIZE = `RAM_SIZE_DEFAULT
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset_n,
  // mode from the rest of the controller
  input  wire logic            special_mode,
  // register port
  input  reg_access_t          reg_req,
  output logic [7:0]           reg_rdata,
  // call and return page write
  input  wire logic            call_page_wr,
  input  wire logic [7:0]      call_page_data,
  // global page index from its own register
  input  wire logic [6:0]      global_page_index,
  // local access from cpu or debug unit
  input  local_access_t        req,
  // translated access and map controls
  output global_access_t       rsp,
  output visibility_t          visibility,
  output logic [7:0]           zero_page_bits,
  output logic [7:0]           program_page_index,
  output logic [7:0]           ram_page_index,
  output logic [7:0]           data_flash_page_index
);
  // ==========================================
  // register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic wr_zero, wr_vis, wr_prog, wr_ram, wr_data;
  assign wr_zero = reg_req.wr && hit(reg_req.addr, `ZERO_PAGE_OFS);
  assign wr_vis  = reg_req.wr && hit(reg_req.addr, `VIS_CTRL_OFS);
  assign wr_prog = reg_req.wr && hit(reg_req.addr, `PROG_PAGE_OFS);
  assign wr_ram  = reg_req.wr && hit(reg_req.addr, `RAM_PAGE_OFS);
  assign wr_data = reg_req.wr && hit(reg_req.addr, `DATA_PAGE_OFS);

  // ==========================================
  // zero page write-once lock
  zero_page_lock_t lock_state;
  zero_page_lock_t next_lock_state;
  logic            zero_accept;

  // special mode keeps the register open, which debug tools rely on
  assign zero_accept = wr_zero && (special_mode || lock_state == ZP_OPEN);

  always_comb begin
    next_lock_state = lock_state;
    unique case (lock_state)
      ZP_OPEN:   next_lock_state = zero_accept ? ZP_LOCKED : ZP_OPEN;
      ZP_LOCKED: next_lock_state = ZP_LOCKED;
    endcase
  end

  // lock only clears on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_state <= ZP_OPEN;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // ==========================================
  // page index registers
  logic [7:0] next_prog_page;

  // call or return wins over a bus write in the same cycle
  assign next_prog_page = call_page_wr ? call_page_data :
                          wr_prog ? reg_req.wdata : program_page_index;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_page_bits <= `ZERO_PAGE_RST;
    end else if (zero_accept) begin
      zero_page_bits <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      program_page_index <= `PROG_PAGE_RST;
    end else begin
      program_page_index <= next_prog_page;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_page_index <= `RAM_PAGE_RST;
    end else if (wr_ram) begin
      ram_page_index <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_flash_page_index <= `DATA_PAGE_RST;
    end else if (wr_data) begin
      data_flash_page_index <= reg_req.wdata;
    end
  end

  // ==========================================
  // visibility control, only implemented bits stored
  visibility_t next_visibility;
  assign next_visibility = '{
    scratch_ram_visible:      reg_req.wdata[`VIS_SCRATCH_BIT],
    data_info_row_visible:    reg_req.wdata[`VIS_DATA_ROW_BIT],
    program_info_row_visible: reg_req.wdata[`VIS_PROG_ROW_BIT]
  };

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      visibility <= '0;
    end else if (wr_vis) begin
      visibility <= next_visibility;
    end
  end

  // ==========================================
  // read path
  logic [7:0] vis_byte;
  logic [7:0] read_value;

  // unimplemented bits stay zero on read
  assign vis_byte = ((8'(visibility.scratch_ram_visible) << `VIS_SCRATCH_BIT)
                  | (8'(visibility.data_info_row_visible) << `VIS_DATA_ROW_BIT)
                  | (8'(visibility.program_info_row_visible) << `VIS_PROG_ROW_BIT))
                  & `VIS_WR_MASK;

  // unmapped offsets read as zero
  assign read_value = hit(reg_req.addr, `ZERO_PAGE_OFS) ? zero_page_bits :
                      hit(reg_req.addr, `VIS_CTRL_OFS)  ? vis_byte :
                      hit(reg_req.addr, `PROG_PAGE_OFS) ? program_page_index :
                      hit(reg_req.addr, `RAM_PAGE_OFS)  ? ram_page_index :
                      hit(reg_req.addr, `DATA_PAGE_OFS) ? data_flash_page_index : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= read_value;
    end
  end

  // ==========================================
  // address translation
  logic [22:0] exp_addr;
  logic        ram_access;

  address_expander u_expander (
    .req                   (req),
    .zero_page_bits        (zero_page_bits),
    .program_page_index    (program_page_index),
    .ram_page_index        (ram_page_index),
    .data_flash_page_index (data_flash_page_index),
    .global_page_index     (global_page_index),
    .global_addr           (exp_addr),
    .ram_access            (ram_access)
  );

  // ram bottom depends on the ram fitted; register space aliases ram page zero
  localparam logic [22:0] RAM_LOW = 23'(`RAM_TOP - RAM_SIZE);

  logic           reg_alias;
  logic           below_ram;
  logic           row_hit;
  global_access_t next_rsp;
  assign reg_alias = ram_access && exp_addr[22:`RAM_OFS_W] == 11'(`REG_SPACE_PAGE);
  assign below_ram = ram_access && !reg_alias && exp_addr < RAM_LOW;
  assign row_hit   = visibility.program_info_row_visible
                  && (exp_addr & `PROG_ROW_MASK) == `PROG_ROW_BASE;
  assign next_rsp  = '{
    valid:          req.valid,
    debug:          req.debug,
    addr:           exp_addr,
    register_space: req.valid && reg_alias,
    unimplemented:  req.valid && below_ram,
    prog_row_hit:   req.valid && row_hit
  };

  // one register stage keeps every output on a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  // ==========================================
  // checks
  logic first_cycle;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  sequence s_local_req(logic [15:0] base, logic [15:0] mask);
    req.valid && !req.global_inst && !req.direct && ((req.addr & mask) == base);
  endsequence

  sequence s_blocked_zero_write;
    wr_zero && !special_mode && lock_state == ZP_LOCKED;
  endsequence

  property p_zero_lock;
    @(posedge clk) disable iff (!reset_n)
      s_blocked_zero_write |=> zero_page_bits == $past(zero_page_bits);
  endproperty
  a_zero_lock: assert property (p_zero_lock) else $error("locked zero page changed");

  property p_zero_special;
    @(posedge clk) disable iff (!reset_n)
      wr_zero && special_mode |=> zero_page_bits == $past(reg_req.wdata) && lock_state == ZP_LOCKED;
  endproperty
  a_zero_special: assert property (p_zero_special) else $error("special write lost");

  // the data window keeps only the low ten local bits, so only those of the zero page survive every region
  // the remaining zero page bits pick the window; the window checks take only non-direct requests, so they do not cover them
  property p_direct_high;
    @(posedge clk) disable iff (!reset_n)
      req.valid && req.direct |=>
        rsp.addr[9:0] == {$past(zero_page_bits[1:0]), $past(req.addr[7:0])} && rsp.valid;
  endproperty
  a_direct_high: assert property (p_direct_high) else $error("direct high byte wrong");

  property p_direct_global;
    @(posedge clk) disable iff (!reset_n)
      req.valid && req.direct && req.global_inst |=> rsp.addr[22:16] == $past(global_page_index);
  endproperty
  a_direct_global: assert property (p_direct_global) else $error("direct global page wrong");

  property p_global_concat;
    @(posedge clk) disable iff (!reset_n)
      req.valid && req.global_inst && !req.direct |=>
        rsp.addr == {$past(global_page_index), $past(req.addr)};
  endproperty
  a_global_concat: assert property (p_global_concat) else $error("global concat wrong");

  property p_prog_window;
    @(posedge clk) disable iff (!reset_n)
      s_local_req(`PROG_WIN_BASE, `PROG_WIN_MASK) |=>
        rsp.addr[21:`PROG_OFS_W] == $past(program_page_index) && rsp.addr[22];
  endproperty
  a_prog_window: assert property (p_prog_window) else $error("program window wrong");

  property p_prog_fixed;
    @(posedge clk) disable iff (!reset_n)
      s_local_req(`PROG_FIX_BASE, `PROG_WIN_MASK) |=> rsp.addr[21:`PROG_OFS_W] == `PROG_FIX_PAGE;
  endproperty
  a_prog_fixed: assert property (p_prog_fixed) else $error("fixed program page wrong");

  // linear flash below the window stays on its own fixed page
  property p_prog_linear;
    @(posedge clk) disable iff (!reset_n)
      s_local_req(`PROG_LIN_BASE, `PROG_WIN_MASK) |=> rsp.addr[21:`PROG_OFS_W] == `PROG_LIN_PAGE;
  endproperty
  a_prog_linear: assert property (p_prog_linear) else $error("linear program page wrong");

  property p_call_write;
    @(posedge clk) disable iff (!reset_n)
      call_page_wr |=> program_page_index == $past(call_page_data);
  endproperty
  a_call_write: assert property (p_call_write) else $error("call page write late");

  property p_reset_pages;
    @(posedge clk) disable iff (!reset_n)
      first_cycle |-> program_page_index == `PROG_PAGE_RST && ram_page_index == `RAM_PAGE_RST;
  endproperty
  a_reset_pages: assert property (p_reset_pages) else $error("page reset value wrong");

  property p_ram_window;
    @(posedge clk) disable iff (!reset_n)
      s_local_req(`RAM_WIN_BASE, `RAM_WIN_MASK) |=>
        rsp.addr[19:`RAM_OFS_W] == $past(ram_page_index) && rsp.addr[22:20] == `RAM_PREFIX;
  endproperty
  a_ram_window: assert property (p_ram_window) else $error("ram window wrong");

  property p_reg_alias;
    @(posedge clk) disable iff (!reset_n)
      s_local_req(`RAM_WIN_BASE, `RAM_WIN_MASK) ##0 (ram_page_index == `REG_SPACE_PAGE) |=>
        rsp.register_space && !rsp.unimplemented;
  endproperty
  a_reg_alias: assert property (p_reg_alias) else $error("register alias missed");

  property p_ram_fixed;
    @(posedge clk) disable iff (!reset_n)
      s_local_req(`RAM_FIX_HI_BASE, `RAM_WIN_MASK) |=> rsp.addr[19:`RAM_OFS_W] == `RAM_FIX_HI_PAGE;
  endproperty
  a_ram_fixed: assert property (p_ram_fixed) else $error("fixed ram page wrong");

  property p_unimpl;
    @(posedge clk) disable iff (!reset_n)
      rsp.unimplemented |-> rsp.addr < RAM_LOW && !rsp.register_space;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented flag wrong");

  property p_data_window;
    @(posedge clk) disable iff (!reset_n)
      s_local_req(`DATA_WIN_BASE, `DATA_WIN_MASK) |=>
        rsp.addr[17:`DATA_OFS_W] == $past(data_flash_page_index) && rsp.debug == $past(req.debug);
  endproperty
  a_data_window: assert property (p_data_window) else $error("data flash window wrong");

  property p_vis_write;
    @(posedge clk) disable iff (!reset_n)
      wr_vis |=> visibility.scratch_ram_visible == $past(reg_req.wdata[`VIS_SCRATCH_BIT])
              && visibility.data_info_row_visible == $past(reg_req.wdata[`VIS_DATA_ROW_BIT])
              && visibility.program_info_row_visible == $past(reg_req.wdata[`VIS_PROG_ROW_BIT]);
  endproperty
  a_vis_write: assert property (p_vis_write) else $error("visibility write lost");

  property p_vis_reserved;
    @(posedge clk) disable iff (!reset_n)
      reg_req.rd && hit(reg_req.addr, `VIS_CTRL_OFS) |=> (reg_rdata & ~`VIS_WR_MASK) == 8'h00;
  endproperty
  a_vis_reserved: assert property (p_vis_reserved) else $error("reserved bits not zero");
endmodule

//--- test/bus_master_model.sv
`timescale 1ns/1ps
// ==========================================
// cpu or debug unit issuing one local access
module bus_master_model
  import mapper_pkg::*;
(
  // clock
  input  wire logic    clk,
  // local access toward the mapper
  output local_access_t req
);
  initial begin
    req = '0;
  end

  // one access per call, held for a whole cycle
  // a released address bus shows the inverse of the last address, not a stale copy
  task automatic access(input logic dbg, input logic dir, input logic glob, input logic [15:0] a);
    @(posedge clk);
    req <= '{valid: 1'b1, debug: dbg, direct: dir, global_inst: glob, addr: a};
    @(posedge clk);
    req <= '{valid: 1'b0, debug: 1'b0, direct: 1'b0, global_inst: 1'b0, addr: ~a};
  endtask
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  import mapper_pkg::*;
  logic           clk;
  logic           reset_n;
  logic           special_mode;
  logic           call_page_wr;
  logic [7:0]     call_page_data;
  logic [6:0]     global_page_index;
  reg_access_t    reg_req;
  local_access_t  req;
  global_access_t rsp;
  visibility_t    visibility;
  logic [7:0]     reg_rdata;
  logic [7:0]     zero_page_bits;
  logic [7:0]     program_page_index;
  logic [7:0]     ram_page_index;
  logic [7:0]     data_flash_page_index;
  int             fails;
  int             num_checks;

  // ==========================================
  // design and master
  page_window_address_mapper #(.RAM_SIZE(32'h0000_3000)) uut (
    .clk(clk), .reset_n(reset_n), .special_mode(special_mode), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .call_page_wr(call_page_wr), .call_page_data(call_page_data),
    .global_page_index(global_page_index), .req(req), .rsp(rsp), .visibility(visibility),
    .zero_page_bits(zero_page_bits), .program_page_index(program_page_index),
    .ram_page_index(ram_page_index), .data_flash_page_index(data_flash_page_index)
  );
  bus_master_model master (.clk(clk), .req(req));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobe; value is settled just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1;
    chk(23'(reg_rdata), 23'(exp));
  endtask

  // flags are register_space, unimplemented, program row hit
  task automatic xlate(input logic dbg, input logic dir, input logic glob, input logic [15:0] a,
                       input logic [22:0] ea, input logic [2:0] ef);
    master.access(dbg, dir, glob, a);
    #1;
    chk(rsp.addr, ea);
    chk(23'({rsp.valid, rsp.debug, rsp.register_space, rsp.unimplemented, rsp.prog_row_hit}),
        23'({1'b1, dbg, ef}));
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    reset_n = 1'b0;
    special_mode = 1'b0;
    call_page_wr = 1'b0;
    call_page_data = 8'h00;
    global_page_index = 7'h00;
    reg_req = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // reset values, read back and through the paged and linear program windows and the ram window
    rchk(8'h15, 8'hFE);
    rchk(8'h16, 8'hFD);
    rchk(8'h17, 8'hFE);
    rchk(8'h11, 8'h00);
    rchk(8'h13, 8'h00);
    xlate(1'b0, 1'b0, 1'b0, 16'h8123, {1'b1, 8'hFE, 14'h0123}, 3'b000);
    xlate(1'b0, 1'b0, 1'b0, 16'h4567, {1'b1, 8'hFD, 14'h0567}, 3'b000);
    xlate(1'b0, 1'b0, 1'b0, 16'h1ABC, {3'b000, 8'hFD, 12'hABC}, 3'b000);
    // program window and fixed top page
    wr(8'h15, 8'h20);
    xlate(1'b1, 1'b0, 1'b0, 16'h8123, {1'b1, 8'h20, 14'h0123}, 3'b000);
    xlate(1'b0, 1'b0, 1'b0, 16'hC456, {1'b1, 8'hFF, 14'h0456}, 3'b000);
    // call write collides with a bus write; the call value must win
    @(posedge clk);
    call_page_wr <= 1'b1;
    call_page_data <= 8'h33;
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h15, wdata: 8'h44};
    @(posedge clk);
    call_page_wr <= 1'b0;
    reg_req <= '0;
    #1;
    chk(23'(program_page_index), 23'h33);
    // ram window, boundary of implemented ram, fixed pages, register alias
    wr(8'h16, 8'hFC);
    xlate(1'b0, 1'b0, 1'b0, 16'h1234, {3'b000, 8'hFC, 12'h234}, 3'b010);
    wr(8'h16, 8'hFD);
    xlate(1'b0, 1'b0, 1'b0, 16'h1234, {3'b000, 8'hFD, 12'h234}, 3'b000);
    xlate(1'b0, 1'b0, 1'b0, 16'h2345, {3'b000, 8'hFE, 12'h345}, 3'b000);
    xlate(1'b1, 1'b0, 1'b0, 16'h3456, {3'b000, 8'hFF, 12'h456}, 3'b000);
    wr(8'h16, 8'h00);
    chk(23'(ram_page_index), 23'h00);
    xlate(1'b0, 1'b0, 1'b0, 16'h1010, {3'b000, 8'h00, 12'h010}, 3'b100);
    // data flash window from the debug unit
    wr(8'h17, 8'h12);
    xlate(1'b1, 1'b0, 1'b0, 16'h0855, {5'b00100, 8'h12, 10'h055}, 3'b000);
    rchk(8'h17, 8'h12);
    chk(23'(data_flash_page_index), 23'h12);
    // zero page: first write sticks, later ones only in special mode
    wr(8'h11, 8'h80);
    rchk(8'h11, 8'h80);
    wr(8'h11, 8'h40);
    rchk(8'h11, 8'h80);
    @(posedge clk);
    special_mode <= 1'b1;
    wr(8'h11, 8'h40);
    rchk(8'h11, 8'h40);
    chk(23'(zero_page_bits), 23'h40);
    @(posedge clk);
    special_mode <= 1'b0;
    xlate(1'b0, 1'b1, 1'b0, 16'h00FF, {1'b1, 8'hFD, 14'h00FF}, 3'b000);
    // global instructions, plain and direct
    @(posedge clk);
    global_page_index <= 7'h14;
    xlate(1'b0, 1'b0, 1'b1, 16'h5000, 23'h14_5000, 3'b000);
    xlate(1'b0, 1'b1, 1'b1, 16'h0007, 23'h14_4007, 3'b000);
    // visibility control and unused bits
    wr(8'h13, 8'hFF);
    rchk(8'h13, 8'hB0);
    chk(23'(visibility), 23'h7);
    @(posedge clk);
    global_page_index <= 7'h40;
    xlate(1'b0, 1'b0, 1'b1, 16'h1234, 23'h40_1234, 3'b001);
    wr(8'h13, 8'h00);
    chk(23'(visibility), 23'h0);
    xlate(1'b0, 1'b0, 1'b1, 16'h1234, 23'h40_1234, 3'b000);
    // unmapped offset reads zero
    wr(8'h12, 8'h5A);
    rchk(8'h12, 8'h00);
    end_of_test();
  end
endmodule
